// ### rtl/afsg_map.vh
`ifndef AFSG_MAP_VH
`define AFSG_MAP_VH

// ============================================================
// Register byte offsets
`define AFSG_A_INIT      12'h000
`define AFSG_A_AVG       12'h004
`define AFSG_A_STAT      12'h008

// ============================================================
// Field positions and reset values
`define AFSG_SEL_LSB     0
`define AFSG_SEL_MSB     2
`define AFSG_SYNC_LSB    3
`define AFSG_SYNC_MSB    4
`define AFSG_SEL_RST     3'h7
`define AFSG_SYNC_RST    2'h0
`define AFSG_AVG_RST     5'h00
`define AFSG_NCH         5

// ============================================================
// Source, sync and operating mode encodings
`define AFSG_SRC_TEMP    3'h5
`define AFSG_SRC_VPWR    3'h6
`define AFSG_SYNC_OFF    2'h0
`define AFSG_SYNC_VALID  2'h1
`define AFSG_SYNC_RESTART 2'h2
`define AFSG_SYNC_MID    2'h3
`define AFSG_MODE_SLEEP  2'h0
`define AFSG_MODE_NORMAL 2'h1
`define AFSG_MODE_FAIL   2'h2

// ============================================================
// Timing in microseconds, clock rate in MHz and prescaler divide ratio in clock cycles
`define AFSG_CLK_MHZ     10
`define AFSG_TURN_ON_DELAY_US 50
`define AFSG_T_SET_US    260
`define AFSG_T_OVF_US    100
`define AFSG_T_DEF_US    6500
`define AFSG_PRESC_DIV   1024

`endif

// ### rtl/afsg_top.v
// The implementer's own choices: the APB register port and the placing of the registers.
`include "afsg_map.vh"

module afsg_top #(
	parameter BLANK_CYC = (`AFSG_TURN_ON_DELAY_US + `AFSG_T_SET_US) * `AFSG_CLK_MHZ,
	parameter OVF_CYC   = `AFSG_T_OVF_US * `AFSG_CLK_MHZ,
	parameter DEF_HALF  = (`AFSG_T_DEF_US * `AFSG_CLK_MHZ) / 2,
	parameter PRE_HALF  = `AFSG_PRESC_DIV / 2
) (
	input  wire        clk_i,
	input  wire        resetn_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	input  wire [1:0]  op_mode_i,
	input  wire [4:0]  pwm_on_i,
	input  wire [4:0]  full_duty_i,
	input  wire [4:0]  inrush_i,
	input  wire [4:0]  out_fault_i,
	input  wire [4:0]  out_enable_i,
	input  wire        pwm_cycle_i,
	input  wire        pwm_clk_fail_i,
	output reg         feedback_enable_o,
	output wire [2:0]  feedback_source_o,
	output reg         current_fb_o,
	output reg  [4:0]  half_range_o,
	output wire [4:0]  offset_sign_o,
	input  wire        sync_pin_i,
	output wire        sync_pin_o,
	output reg         sync_pin_oe_o
);

// ============================================================
// Cycle counts sized for the counters
localparam [16:0] BLANK_C = BLANK_CYC[16:0];
localparam [16:0] OVF_C   = OVF_CYC[16:0];
localparam [16:0] DEF_C   = DEF_HALF[16:0];
localparam [16:0] PRE_C   = PRE_HALF[16:0];

function is_cur;
	input [2:0] s;
	begin
		is_cur = (s < `AFSG_SRC_TEMP);
	end
endfunction

// Picks the selected channel's bit; zero for non-current sources
function pick;
	input [4:0] v;
	input [2:0] s;
	begin
		pick = is_cur(s) ? v[s] : 1'b0;
	end
endfunction

// Temperature and supply sources share the free-running square wave
function is_volt;
	input [2:0] s;
	begin
		is_volt = (s == `AFSG_SRC_TEMP) | (s == `AFSG_SRC_VPWR);
	end
endfunction

// Full 12-bit compare, so aliases of a register are refused
function addr_hit;
	input [11:0] a;
	input [11:0] off;
	begin
		addr_hit = (a == off);
	end
endfunction

// Counts up and wraps to zero on the terminal tick
function [16:0] wrap_up;
	input [16:0] cnt;
	input        tick;
	begin
		if (tick)
			wrap_up = 17'h0_0000;
		else
			wrap_up = cnt + 17'h0_0001;
	end
endfunction

// Loads on a start event, otherwise runs down and rests at zero
function [16:0] run_down;
	input [16:0] cnt;
	input        start;
	input [16:0] val;
	begin
		if (start)
			run_down = val;
		else if (cnt != 17'h0_0000)
			run_down = cnt - 17'h0_0001;
		else
			run_down = 17'h0_0000;
	end
endfunction

// ============================================================
// Register bus
reg  [2:0]  fb_sel;
reg  [1:0]  sync_mode;
reg  [4:0]  avg_en;
reg  [4:0]  offset_sign;
reg  [4:0]  fault_hold;
reg  [16:0] blank_cnt;
reg         restart_wait;
reg         mid_blank;
reg  [31:0] rd_mux;
wire        acc     = psel_i & penable_i;
wire        hit_i   = addr_hit(paddr_i, `AFSG_A_INIT);
wire        hit_a   = addr_hit(paddr_i, `AFSG_A_AVG);
// Status is read only; writes to it are dropped without an error
wire        hit_s   = addr_hit(paddr_i, `AFSG_A_STAT);
wire        mapped  = hit_i | hit_a | hit_s;
wire        wr      = acc & pwrite_i & mapped;

// No wait states: every access completes in its first access cycle
assign pready_o  = 1'b1;
assign pslverr_o = acc & ~mapped;

always @* begin
	rd_mux = 32'h0000_0000;
	if (hit_i)
		rd_mux[4:0] = {sync_mode, fb_sel};
	else if (hit_a)
		rd_mux[4:0] = avg_en;
	else if (hit_s)
		rd_mux[16:0] = {op_mode_i, current_fb_o, sync_pin_oe_o, mid_blank,
			restart_wait, (blank_cnt != 17'h0_0000), fault_hold,
			offset_sign};
end

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		fb_sel    <= `AFSG_SEL_RST;
		sync_mode <= `AFSG_SYNC_RST;
		avg_en    <= `AFSG_AVG_RST;
		prdata_o  <= 32'h0000_0000;
	end else begin
		// Read data is captured in the setup cycle and held through access
		if (psel_i & ~penable_i)
			prdata_o <= rd_mux;
		if (wr & hit_i) begin
			fb_sel    <= pwdata_i[`AFSG_SEL_MSB:`AFSG_SEL_LSB];
			sync_mode <= pwdata_i[`AFSG_SYNC_MSB:`AFSG_SYNC_LSB];
		end
		if (wr & hit_a)
			avg_en <= pwdata_i[4:0];
	end
end

// ============================================================
// Channel view and analog feedback control
wire        normal   = (op_mode_i == `AFSG_MODE_NORMAL);
wire        fail     = (op_mode_i == `AFSG_MODE_FAIL);
wire        cur_src  = is_cur(fb_sel);
wire        volt_src = is_volt(fb_sel);
wire        on_sel   = pick(pwm_on_i, fb_sel);
wire        inr_sel  = pick(inrush_i, fb_sel);
wire        full_sel = pick(full_duty_i, fb_sel);
wire        flt_sel  = pick(fault_hold, fb_sel);
wire [4:0]  avg_act  = avg_en & {5{~fail}};
wire        avg_sel  = pick(avg_act, fb_sel);
// Non-current sources never gate on, since pick returns zero for them
wire        fb_gate  = normal & cur_src & on_sel & ~inr_sel;

assign feedback_source_o = fb_sel;
assign offset_sign_o     = offset_sign;
// The pin only ever pulls low; the external pull-up makes the high
assign sync_pin_o        = 1'b0;

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		feedback_enable_o <= 1'b0;
		current_fb_o      <= 1'b0;
		half_range_o      <= 5'h00;
	end else begin
		feedback_enable_o <= normal;
		current_fb_o      <= fb_gate;
		half_range_o      <= avg_act;
	end
end

// ============================================================
// Change detection and offset toggling
reg  [2:0]  prev_sel;
reg         pin_prev;
reg  [4:0]  en_prev;
wire        sel_chg  = (fb_sel != prev_sel);
wire        pin_rise = sync_pin_i & ~pin_prev;
wire [4:0]  en_rise  = out_enable_i & ~en_prev;
wire        off_sw   = normal & cur_src & avg_sel & pin_rise;
reg  [4:0]  next_offset_sign;
reg  [4:0]  next_fault_hold;

always @* begin
	next_offset_sign = offset_sign;
	if (off_sw)
		next_offset_sign[fb_sel] = ~offset_sign[fb_sel];
	// A fault in the same cycle as re-enable keeps the hold
	next_fault_hold = (fault_hold & ~en_rise) | out_fault_i;
end

// Previous pin level resets high, the pull-up's idle level: no false edge

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		prev_sel    <= `AFSG_SEL_RST;
		pin_prev    <= 1'b1;
		en_prev     <= 5'h00;
		offset_sign <= 5'h00;
		fault_hold  <= 5'h00;
	end else begin
		prev_sel <= fb_sel;
		pin_prev <= sync_pin_i;
		en_prev  <= out_enable_i;
		offset_sign <= next_offset_sign;
		fault_hold  <= next_fault_hold;
	end
end

// ============================================================
// Blanking, restart wait and midpoint tracking
reg  [16:0] on_cnt;
reg  [16:0] last_len;
reg  [16:0] ovf_cnt;
wire        blanking = (blank_cnt != 17'h0_0000);
wire        past_mid = on_sel & (on_cnt >= {1'b0, last_len[16:1]});
wire        ovf_hi   = (ovf_cnt != 17'h0_0000);

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		blank_cnt    <= 17'h0_0000;
		restart_wait <= 1'b0;
		mid_blank    <= 1'b0;
		on_cnt       <= 17'h0_0000;
		last_len     <= 17'h0_0000;
		ovf_cnt      <= 17'h0_0000;
	end else begin
		blank_cnt <= run_down(blank_cnt, sel_chg | off_sw, BLANK_C);
		// Restart wait outlives the blank when the PWM period is long
		if (sel_chg)
			restart_wait <= 1'b1;
		else if (pwm_cycle_i)
			restart_wait <= 1'b0;
		if (sel_chg)
			mid_blank <= 1'b1;
		else if (past_mid)
			mid_blank <= 1'b0;
		// On-pulse length of the last complete pulse sets the midpoint
		// The first pulse after reset has no history and passes at once
		if (on_sel) begin
			if (on_cnt != 17'h1_ffff)
				on_cnt <= on_cnt + 17'h0_0001;
		end else begin
			if (on_cnt != 17'h0_0000)
				last_len <= on_cnt;
			on_cnt <= 17'h0_0000;
		end
		// Overflow pulse counter only matters while full duty is set
		ovf_cnt <= run_down(ovf_cnt, pwm_cycle_i, OVF_C);
	end
end

// ============================================================
// Free-running square waves
reg  [16:0] pre_cnt;
reg  [16:0] def_cnt;
reg         pre_sq;
reg         def_sq;
// Both dividers run freely, so switching sources may cut a half wave
wire        pre_tick = (pre_cnt == PRE_C - 17'h0_0001);
wire        def_tick = (def_cnt == DEF_C - 17'h0_0001);

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i) begin
		pre_cnt <= 17'h0_0000;
		def_cnt <= 17'h0_0000;
		pre_sq  <= 1'b1;
		def_sq  <= 1'b1;
	end else begin
		pre_cnt <= wrap_up(pre_cnt, pre_tick);
		def_cnt <= wrap_up(def_cnt, def_tick);
		if (pre_tick)
			pre_sq <= ~pre_sq;
		if (def_tick)
			def_sq <= ~def_sq;
	end
end

// ============================================================
// Sync pin drive; high output enable pulls the pin low
reg act_cur;
reg next_drive;
wire valid = fb_gate & ~flt_sel & ~blanking;

always @* begin
	act_cur = 1'b0;
	case (sync_mode)
	`AFSG_SYNC_OFF:
		act_cur = 1'b0;
	`AFSG_SYNC_VALID:
		act_cur = valid;
	`AFSG_SYNC_RESTART:
		// Full duty has no off phase; the overflow pulse marks the cycle
		if (full_sel)
			act_cur = ~ovf_hi & ~inr_sel & ~flt_sel & ~restart_wait;
		else
			act_cur = valid & ~restart_wait;
	`AFSG_SYNC_MID:
		if (full_sel)
			act_cur = ~ovf_hi & ~inr_sel & ~flt_sel & ~mid_blank;
		else
			act_cur = valid & past_mid & ~mid_blank;
	default:
		act_cur = 1'b0;
	endcase
end

always @* begin
	next_drive = 1'b0;
	if (!normal)
		next_drive = 1'b0;
	// Clock failure wins over the selected source's own sync behaviour
	else if (pwm_clk_fail_i & (cur_src | volt_src))
		next_drive = ~def_sq;
	else if (volt_src)
		next_drive = ~pre_sq;
	else if (cur_src)
		next_drive = act_cur;
end

always @(posedge clk_i or negedge resetn_i) begin
	if (!resetn_i)
		sync_pin_oe_o <= 1'b0;
	else
		sync_pin_oe_o <= next_drive;
end

endmodule // afsg_top

// ### test/afsg_asserts.sv
module afsg_asserts #(
	parameter DEF_HALF = 8,
	parameter PRE_HALF = 8
) (
	input wire       clk_i,
	input wire       resetn_i,
	input wire [1:0] op_mode_i,
	input wire [4:0] pwm_on_i,
	input wire [4:0] inrush_i,
	input wire       pwm_clk_fail_i,
	input wire       feedback_enable_o,
	input wire [2:0] feedback_source_o,
	input wire       current_fb_o,
	input wire [4:0] half_range_o,
	input wire       sync_pin_o,
	input wire       sync_pin_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	int hi_cnt;
	always_ff @(posedge clk_i or negedge resetn_i)
		if (!resetn_i)
			hi_cnt <= 0;
		else
			hi_cnt <= sync_pin_oe_o ? hi_cnt + 1 : 0;
	// Past depth spans a whole wave, so a cut first half wave is skipped
	sequence s_wave_end;
		$fell(sync_pin_oe_o) && op_mode_i == 2'h1 &&
			$past(op_mode_i, 40) == 2'h1;
	endsequence
	a_fb_normal_only: assert property (1'b1 |=>
		feedback_enable_o == ($past(op_mode_i) == 2'h1))
		else $error("feedback enable wrong");
	a_sync_normal_only: assert property (op_mode_i != 2'h1 |=>
		!sync_pin_oe_o) else $error("sync outside normal");
	a_pin_low_only: assert property (sync_pin_o == 1'b0)
		else $error("sync drives high");
	a_fb_inrush_off: assert property (feedback_source_o < 3'h5 &&
		inrush_i[feedback_source_o] |=> !current_fb_o)
		else $error("feedback in inrush");
	a_fb_phase_off: assert property (feedback_source_o < 3'h5 &&
		!pwm_on_i[feedback_source_o] |=> !current_fb_o)
		else $error("feedback in off phase");
	a_sync_inrush_off: assert property (feedback_source_o < 3'h5 &&
		inrush_i[feedback_source_o] && !pwm_clk_fail_i |=> !sync_pin_oe_o)
		else $error("sync in inrush");
	a_avg_fail_off: assert property (op_mode_i == 2'h2 |=>
		half_range_o == 5'h00) else $error("averaging in fail");
	a_fail_wave: assert property (s_wave_end ##0 (pwm_clk_fail_i &&
		$past(pwm_clk_fail_i, 40)) |-> hi_cnt == DEF_HALF)
		else $error("fail wave length");
	a_volt_wave: assert property (s_wave_end ##0 (!pwm_clk_fail_i &&
		!$past(pwm_clk_fail_i, 40) && feedback_source_o inside {3'h5, 3'h6}
		&& $past(feedback_source_o, 40) == feedback_source_o) |->
		hi_cnt == PRE_HALF) else $error("voltage wave length");
endmodule // afsg_asserts

bind afsg_top afsg_asserts #(.DEF_HALF(DEF_HALF), .PRE_HALF(PRE_HALF)) u_chk (
	.clk_i, .resetn_i, .op_mode_i, .pwm_on_i, .inrush_i, .pwm_clk_fail_i,
	.feedback_enable_o, .feedback_source_o, .current_fb_o, .half_range_o,
	.sync_pin_o, .sync_pin_oe_o);

// ### test/afsg_mcu_model.sv
module afsg_mcu_model (
	input  wire logic sync_pin_oe_i,
	input  wire logic sync_pin_drv_i,
	output wire logic sync_wire_o,
	output int        edges_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pull-up holds the wire high whenever the device lets go
	assign sync_wire_o = sync_pin_oe_i ? sync_pin_drv_i : 1'b1;
	initial edges_o = 0;
	always @(negedge sync_wire_o) edges_o++;
endmodule // afsg_mcu_model

// ### test/afsg_tb.sv
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end

module afsg_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0;
	logic        penable_i = 1'b0, pwrite_i = 1'b0, pwm_cycle_i = 1'b0;
	logic        pwm_clk_fail_i = 1'b0, e, exp_fb, exp_en;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, q, r;
	logic [1:0]  op_mode_i = 2'h1, p10 = 2'h0;
	logic [2:0]  rnd3 = 3'h0, sel_m;
	logic [4:0]  full_duty_i = 5'h00, inrush_i = 5'h00, out_fault_i = 5'h00;
	logic [4:0]  out_enable_i = 5'h1f;
	wire  [4:0]  pwm_on_i = {rnd3, p10};
	wire  [31:0] prdata_o;
	wire  [4:0]  half_range_o, offset_sign_o;
	wire  [2:0]  feedback_source_o;
	wire         pready_o, pslverr_o, feedback_enable_o, current_fb_o;
	wire         sync_pin_i, sync_pin_o, sync_pin_oe_o;
	int          num_errors = 0, checked = 0, seed = 22176, edges, n0;

	always #50 clk_i = ~clk_i;

	afsg_top #(.BLANK_CYC(20), .OVF_CYC(10), .DEF_HALF(8),
		.PRE_HALF(8)) dut (.clk_i, .resetn_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
		.op_mode_i, .pwm_on_i, .full_duty_i, .inrush_i, .out_fault_i,
		.out_enable_i, .pwm_cycle_i, .pwm_clk_fail_i, .feedback_enable_o,
		.feedback_source_o, .current_fb_o, .half_range_o, .offset_sign_o,
		.sync_pin_i, .sync_pin_o, .sync_pin_oe_o);
	afsg_mcu_model u_mcu (.sync_pin_oe_i(sync_pin_oe_o),
		.sync_pin_drv_i(sync_pin_o), .sync_wire_o(sync_pin_i), .edges_o(edges));

	// ========
	// Reference model, compared every cycle
	always @(posedge clk_i or negedge resetn_i)
		if (!resetn_i) begin
			sel_m <= 3'h7;
			exp_fb <= 1'b0;
			exp_en <= 1'b0;
		end else begin
			exp_en <= op_mode_i == 2'h1;
			exp_fb <= op_mode_i == 2'h1 && sel_m < 3'h5 && pwm_on_i[sel_m] &&
				!inrush_i[sel_m];
			if (psel_i && penable_i && pwrite_i && paddr_i == 12'h000)
				sel_m <= pwdata_i[2:0];
			rnd3 <= 3'($random(seed));
		end
	always @(negedge clk_i)
		if (resetn_i) begin
			`CHK(feedback_source_o, sel_m)
			`CHK(feedback_enable_o, exp_en)
			`CHK(current_fb_o, exp_fb)
		end

	task automatic close_out;
		if (num_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			close_out();
		end
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic cfg(input logic [1:0] m, input logic [2:0] s);
		apb(1'b1, 12'h000, {27'h0, m, s});
		cyc(30);
	endtask
	task automatic trig(input logic [1:0] p);
		p10 <= p;
		cyc(3);
	endtask

	// ========
	// Main sequence
	initial begin
		cyc(8);
		resetn_i <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		`CHK(q[4:0], 5'h07)
		apb(1'b1, 12'h00c, 32'h1);
		`CHK(e, 1'b1)
		r = $random(seed) | 32'h1;
		apb(1'b1, 12'h004, r);
		apb(1'b0, 12'h004, 32'h0);
		`CHK(q, r & 32'h1f)
		`CHK(half_range_o, r[4:0])
		op_mode_i <= 2'h2;
		cyc(3);
		op_mode_i <= 2'h1;
		p10 <= 2'b01;
		cfg(2'h1, 3'h0);
		`CHK(sync_pin_oe_o, 1'b1)
		n0 = offset_sign_o[0];
		trig(2'b00);
		`CHK(sync_pin_oe_o, 1'b0)
		`CHK(offset_sign_o[0], ~n0[0])
		trig(2'b01);
		`CHK(sync_pin_oe_o, 1'b0)
		cyc(25);
		`CHK(sync_pin_oe_o, 1'b1)
		inrush_i <= 5'h01;
		cyc(3);
		`CHK(sync_pin_oe_o, 1'b0)
		inrush_i <= 5'h00;
		out_fault_i <= 5'h01;
		cyc(1);
		out_fault_i <= 5'h00;
		cyc(30);
		`CHK(sync_pin_oe_o, 1'b0)
		out_enable_i <= 5'h1e;
		cyc(2);
		out_enable_i <= 5'h1f;
		cyc(30);
		`CHK(sync_pin_oe_o, 1'b1)
		cfg(2'h0, 3'h0);
		`CHK(sync_pin_oe_o, 1'b0)
		p10 <= 2'b11;
		cfg(2'h2, 3'h1);
		`CHK(sync_pin_oe_o, 1'b0)
		pwm_cycle_i <= 1'b1;
		cyc(1);
		pwm_cycle_i <= 1'b0;
		cyc(3);
		`CHK(sync_pin_oe_o, 1'b1)
		p10 <= 2'b00;
		cfg(2'h3, 3'h0);
		for (int i = 0; i < 3; i++) begin
			trig(2'b01);
			`CHK(sync_pin_oe_o, 1'b0)
			cyc(7);
			if (i > 0)
				`CHK(sync_pin_oe_o, 1'b1)
			cyc(2);
			p10 <= 2'b00;
			cyc(30);
		end
		full_duty_i <= 5'h01;
		p10 <= 2'b01;
		cyc(30);
		`CHK(sync_pin_oe_o, 1'b1)
		pwm_cycle_i <= 1'b1;
		cyc(1);
		pwm_cycle_i <= 1'b0;
		cyc(4);
		`CHK(sync_pin_oe_o, 1'b0)
		cyc(30);
		`CHK(sync_pin_oe_o, 1'b1)
		full_duty_i <= 5'h00;
		apb(1'b1, 12'h004, 32'h0);
		cfg(2'h0, 3'h5);
		n0 = edges;
		cyc(40);
		`CHK(edges - n0 > 1, 1'b1)
		pwm_clk_fail_i <= 1'b1;
		cyc(60);
		op_mode_i <= 2'h2;
		cyc(3);
		`CHK(sync_pin_oe_o, 1'b0)
		resetn_i <= 1'b0;
		pwm_clk_fail_i <= 1'b0;
		op_mode_i <= 2'h1;
		cyc(3);
		resetn_i <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		`CHK(q[4:0], 5'h07)
		close_out();
	end
endmodule // afsg_tb
